/* File: inc/asp_pkg.sv */
// Constants shared by the serial port core and its bit-rate timers.
// Assumes one 250 MHz system clock and a 32-bit AHB-Lite register bus.
package asp_pkg;
	// Register byte addresses
	localparam logic [31:0] ASP_CTRL_ADDR = 32'h0000_0098;
	localparam logic [31:0] ASP_DATA_ADDR = 32'h0000_009C;
	localparam logic [31:0] ASP_TIMER_ADDR = 32'h0000_00A0;
	// Control register fields
	localparam int ASP_FRAMING_BIT = 7;
	localparam int ASP_UNUSED_BIT = 6;
	localparam int ASP_FILTER_BIT = 5;
	localparam int ASP_REN_BIT = 4;
	localparam int ASP_TB8_BIT = 3;
	localparam int ASP_RB8_BIT = 2;
	localparam int ASP_TI_BIT = 1;
	localparam int ASP_RI_BIT = 0;
	localparam logic [7:0] ASP_CTRL_RESET = 8'h40;
	localparam logic [7:0] ASP_DATA_RESET = 8'h00;
	// Timer register fields
	localparam int ASP_RUN_BIT = 8;
	localparam int ASP_IE_BIT = 9;
	localparam logic [7:0] ASP_RELOAD_RESET = 8'h00;
	// Counter overflow value
	localparam logic [7:0] ASP_CNT_TOP = 8'hFF;
	// Bits after the start bit: data, optional ninth, stop
	localparam logic [3:0] ASP_BITS_8 = 4'h9;
	localparam logic [3:0] ASP_BITS_9 = 4'hA;
	localparam logic [3:0] ASP_DATA_BITS = 4'h8;
	// AHB encodings
	localparam logic [1:0] ASP_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] ASP_HTRANS_SEQ = 2'h3;

	typedef enum logic [1:0] {
		ASP_RX_IDLE,
		ASP_RX_START,
		ASP_RX_BITS
	} asp_rx_state_t;
endpackage

/* File: rtl/asp_bit_timer.sv */
// Eight-bit auto-reload counter whose overflows, halved, give bit ticks.
// Assumes run and reload are steady register outputs of the same clock.
`timescale 1ns/1ps
module asp_bit_timer
	import asp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire logic run,
	input wire logic [7:0] reload,
	input wire logic force_reload,
	// Ticks
	output logic ovf,
	output logic bit_tick
);
	logic [7:0] cnt;
	logic phase;

	// Two overflows make one bit time; a forced reload arms the half phase
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt <= ASP_RELOAD_RESET;
			phase <= 1'b0;
			ovf <= 1'b0;
			bit_tick <= 1'b0;
		end else if (force_reload) begin
			cnt <= reload;
			phase <= 1'b1;
			ovf <= 1'b0;
			bit_tick <= 1'b0;
		end else if (run) begin
			ovf <= (cnt == ASP_CNT_TOP);
			bit_tick <= (cnt == ASP_CNT_TOP) && phase;
			if (cnt == ASP_CNT_TOP) begin
				cnt <= reload;
				phase <= ~phase;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end else begin
			ovf <= 1'b0;
			bit_tick <= 1'b0;
		end
	end

	// Helper: overflows seen since the last bit tick
	logic [1:0] ovf_seen;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ovf_seen <= 2'h0;
		end else if (force_reload) begin
			// A forced reload arms the phase, so its first overflow is a tick
			ovf_seen <= 2'h1;
		end else if (bit_tick) begin
			ovf_seen <= 2'h0;
		end else if (ovf && ovf_seen != 2'h3) begin
			ovf_seen <= ovf_seen + 2'h1;
		end
	end

	tick_ratio_a: assert property (@(posedge clk) disable iff (!resetn)
		bit_tick |-> $past(ovf_seen) == 2'h1)
		else $error("bit tick not on second overflow");
endmodule

/* File: rtl/asp_uart.sv */
// Full-duplex serial port with 8- and 9-bit framing behind an AHB-Lite slave.
// Assumes synchronous pins, single word transfers and a 250 MHz clock.
`timescale 1ns/1ps
module asp_uart
	import asp_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Serial pins
	output logic serial_transmit_pin,
	input wire logic serial_receive_pin,
	// Interrupt request
	output logic irq
);
	// Control, data and timer register bits
	logic framing_select;
	logic filter_enable;
	logic receive_enable_bit;
	logic ninth_transmit_bit;
	logic ninth_receive_bit;
	logic transmit_complete_flag;
	logic receive_flag;
	logic [7:0] receive_latch;
	logic [7:0] bit_rate_reload_value;
	logic timer_run;
	logic irq_enable;

	// Bus pipeline
	logic wr_pend;
	logic [31:0] wr_addr;
	logic rd_pend;
	logic [31:0] rd_addr;
	logic addr_phase;
	logic ctrl_wr;
	logic data_wr;
	logic timer_wr;
	logic [7:0] ctrl_read;

	// Transmitter
	logic tx_pend;
	logic [7:0] tx_data;
	logic [9:0] tx_shift;
	logic [3:0] tx_left;
	logic tx_tick;

	// Receiver
	asp_rx_state_t rx_state;
	logic rx_prev;
	logic [7:0] rx_data;
	logic rx_ninth;
	logic [3:0] rx_cnt;
	logic rx_tick;
	logic rx_force;
	logic rx_stop_tick;
	logic rx_bit8;
	logic rx_accept;

	assign addr_phase = hsel && hready
		&& (htrans == ASP_HTRANS_NONSEQ || htrans == ASP_HTRANS_SEQ);
	assign ctrl_wr = wr_pend && (wr_addr == ASP_CTRL_ADDR);
	assign data_wr = wr_pend && (wr_addr == ASP_DATA_ADDR);
	assign timer_wr = wr_pend && (wr_addr == ASP_TIMER_ADDR);
	assign ctrl_read = {framing_select, 1'b1, filter_enable, receive_enable_bit,
		ninth_transmit_bit, ninth_receive_bit, transmit_complete_flag, receive_flag};

	// Address phase capture; reads take one wait state so writes settle first
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h0000_0000;
			rd_pend <= 1'b0;
			rd_addr <= 32'h0000_0000;
		end else begin
			wr_pend <= addr_phase && hwrite;
			rd_pend <= addr_phase && !hwrite;
			if (addr_phase) begin
				wr_addr <= haddr;
				rd_addr <= haddr;
			end
		end
	end

	// Bus answer; unmapped reads return zero, every response is OKAY
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			hresp <= 1'b0;
			hreadyout <= !(addr_phase && !hwrite);
			if (rd_pend) begin
				unique case (rd_addr)
					ASP_CTRL_ADDR: hrdata <= {24'h00_0000, ctrl_read};
					ASP_DATA_ADDR: hrdata <= {24'h00_0000, receive_latch};
					ASP_TIMER_ADDR: hrdata <= {22'h00_0000, irq_enable, timer_run,
						bit_rate_reload_value};
					default: hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Software-owned control bits
	always_ff @(posedge clk) begin
		if (!resetn) begin
			framing_select <= ASP_CTRL_RESET[ASP_FRAMING_BIT];
			filter_enable <= ASP_CTRL_RESET[ASP_FILTER_BIT];
			receive_enable_bit <= ASP_CTRL_RESET[ASP_REN_BIT];
			ninth_transmit_bit <= ASP_CTRL_RESET[ASP_TB8_BIT];
		end else if (ctrl_wr) begin
			framing_select <= hwdata[ASP_FRAMING_BIT];
			filter_enable <= hwdata[ASP_FILTER_BIT];
			receive_enable_bit <= hwdata[ASP_REN_BIT];
			ninth_transmit_bit <= hwdata[ASP_TB8_BIT];
		end
	end

	// Timer reload, run and interrupt enable
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bit_rate_reload_value <= ASP_RELOAD_RESET;
			timer_run <= 1'b0;
			irq_enable <= 1'b0;
		end else if (timer_wr) begin
			bit_rate_reload_value <= hwdata[7:0];
			timer_run <= hwdata[ASP_RUN_BIT];
			irq_enable <= hwdata[ASP_IE_BIT];
		end
	end

	// Transmit and receive bit clocks from separate counter copies
	asp_bit_timer u_tx_timer (
		.clk(clk),
		.resetn(resetn),
		.run(timer_run),
		.reload(bit_rate_reload_value),
		.force_reload(1'b0),
		.ovf(),
		.bit_tick(tx_tick)
	);

	asp_bit_timer u_rx_timer (
		.clk(clk),
		.resetn(resetn),
		.run(timer_run),
		.reload(bit_rate_reload_value),
		.force_reload(rx_force),
		.ovf(),
		.bit_tick(rx_tick)
	);

	// Transmit shifter; a write during a frame restarts with the new byte
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_pend <= 1'b0;
			tx_data <= ASP_DATA_RESET;
			tx_shift <= 10'h3FF;
			tx_left <= 4'h0;
			serial_transmit_pin <= 1'b1;
		end else if (data_wr) begin
			tx_pend <= 1'b1;
			tx_data <= hwdata[7:0];
		end else if (tx_tick) begin
			if (tx_pend) begin
				tx_pend <= 1'b0;
				serial_transmit_pin <= 1'b0;
				if (framing_select) begin
					tx_shift <= {1'b1, ninth_transmit_bit, tx_data};
					tx_left <= ASP_BITS_9;
				end else begin
					tx_shift <= {2'h3, tx_data};
					tx_left <= ASP_BITS_8;
				end
			end else if (tx_left != 4'h0) begin
				serial_transmit_pin <= tx_shift[0];
				tx_shift <= {1'b1, tx_shift[9:1]};
				tx_left <= tx_left - 4'h1;
			end else begin
				serial_transmit_pin <= 1'b1;
			end
		end
	end

	// Receive start detection and bit counting
	assign rx_force = (rx_state == ASP_RX_IDLE) && receive_enable_bit && rx_prev
		&& !serial_receive_pin;
	assign rx_stop_tick = rx_tick && receive_enable_bit && (rx_state == ASP_RX_BITS)
		&& (rx_cnt == (framing_select ? ASP_BITS_9 : ASP_BITS_8) - 4'h1);
	assign rx_bit8 = framing_select ? rx_ninth : serial_receive_pin;
	assign rx_accept = !receive_flag && (!filter_enable || rx_bit8);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_prev <= 1'b1;
		end else begin
			rx_prev <= serial_receive_pin;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_state <= ASP_RX_IDLE;
			rx_cnt <= 4'h0;
			rx_data <= ASP_DATA_RESET;
			rx_ninth <= 1'b0;
		end else if (!receive_enable_bit) begin
			rx_state <= ASP_RX_IDLE;
		end else begin
			unique case (rx_state)
				ASP_RX_IDLE: begin
					rx_cnt <= 4'h0;
					if (rx_force) begin
						rx_state <= ASP_RX_START;
					end
				end
				ASP_RX_START: begin
					if (rx_tick) begin
						// A high line at mid start bit was only a glitch
						rx_state <= serial_receive_pin ? ASP_RX_IDLE : ASP_RX_BITS;
					end
				end
				ASP_RX_BITS: begin
					if (rx_tick) begin
						rx_cnt <= rx_cnt + 4'h1;
						if (rx_cnt < ASP_DATA_BITS) begin
							rx_data[rx_cnt[2:0]] <= serial_receive_pin;
						end else if (rx_cnt == ASP_DATA_BITS) begin
							rx_ninth <= serial_receive_pin;
						end
						if (rx_stop_tick) begin
							rx_state <= ASP_RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Receive latch loads only on acceptance, so an overrun keeps the old byte
	always_ff @(posedge clk) begin
		if (!resetn) begin
			receive_latch <= ASP_DATA_RESET;
		end else if (rx_stop_tick && rx_accept) begin
			receive_latch <= rx_data;
		end
	end

	// Ninth receive bit: hardware load wins over a software write
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ninth_receive_bit <= ASP_CTRL_RESET[ASP_RB8_BIT];
		end else if (rx_stop_tick && rx_accept) begin
			ninth_receive_bit <= rx_bit8;
		end else if (ctrl_wr) begin
			ninth_receive_bit <= hwdata[ASP_RB8_BIT];
		end
	end

	// Flags: a hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			transmit_complete_flag <= ASP_CTRL_RESET[ASP_TI_BIT];
			receive_flag <= ASP_CTRL_RESET[ASP_RI_BIT];
		end else begin
			if (tx_tick && !tx_pend && tx_left == 4'h1) begin
				transmit_complete_flag <= 1'b1;
			end else if (ctrl_wr) begin
				transmit_complete_flag <= hwdata[ASP_TI_BIT];
			end
			if (rx_stop_tick && rx_accept) begin
				receive_flag <= 1'b1;
			end else if (ctrl_wr) begin
				receive_flag <= hwdata[ASP_RI_BIT];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_enable && (transmit_complete_flag || receive_flag);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence ctrl_read_s;
		addr_phase && !hwrite && haddr == ASP_CTRL_ADDR;
	endsequence

	sequence frame_load_s;
		tx_tick && tx_pend && !data_wr;
	endsequence

	frame_start_a: assert property (frame_load_s |=> !serial_transmit_pin
		&& tx_left == (framing_select ? ASP_BITS_9 : ASP_BITS_8))
		else $error("frame did not start after data write");
	ninth_sent_a: assert property (frame_load_s ##0 framing_select
		|=> tx_shift[8] == $past(ninth_transmit_bit))
		else $error("ninth transmit bit not loaded");
	tx_done_a: assert property (tx_tick && !tx_pend && !data_wr && tx_left == 4'h1
		|=> transmit_complete_flag && serial_transmit_pin)
		else $error("transmit flag not set at stop bit");
	rx_disabled_a: assert property (!receive_enable_bit |=> rx_state == ASP_RX_IDLE
		&& !receive_flag || $past(receive_flag) || $past(ctrl_wr))
		else $error("receiver ran while disabled");
	rx_accept_a: assert property (rx_stop_tick && rx_accept |=> receive_flag
		&& receive_latch == $past(rx_data) && ninth_receive_bit == $past(rx_bit8))
		else $error("accepted character not stored");
	rx_reject_a: assert property (rx_stop_tick && !rx_accept |=>
		$stable(receive_latch) && (receive_flag == $past(receive_flag) || $past(ctrl_wr)))
		else $error("rejected character changed the latch");
	irq_level_a: assert property (irq_enable
		&& (transmit_complete_flag || receive_flag) && !timer_wr |=> irq)
		else $error("interrupt request missing");
	flag_hold_a: assert property (receive_flag && !ctrl_wr |=> receive_flag)
		else $error("receive flag cleared by hardware");
	unused_one_a: assert property (ctrl_read_s |-> ##2
		hrdata[ASP_UNUSED_BIT] && hreadyout)
		else $error("unused control bit did not read one");
	rx_force_a: assert property (rx_force |=> rx_state == ASP_RX_START
		|| !$past(receive_enable_bit))
		else $error("start edge not taken");
endmodule

/* File: testbench/asp_peer.sv */
// Remote serial peer: sends frames to the port and decodes the frames it sends.
// Assumes a bit time of eight clocks, reload 0xFC, and a line that idles high.
`timescale 1ns/1ps
module asp_peer (
	// Clock
	input wire logic clk,
	// Line from the port
	input wire logic rx,
	// Line to the port
	output logic tx
);
	logic nine;
	logic prev;
	logic [9:0] got;
	int frames;
	initial begin
		tx = 1'b1;
		nine = 1'b0;
		prev = 1'b1;
		got = 10'h0;
		frames = 0;
	end
	// Start, data LSB first, optional ninth, stop; a low stop only when asked
	task automatic send(input logic [7:0] d, input logic b9, input logic stop);
		logic [10:0] f;
		int n;
		f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
		n = nine ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			tx <= f[i];
			repeat (8) @(posedge clk);
		end
		tx <= 1'b1;
	endtask
	// Falling edge marks a start; each bit is taken near its middle
	always begin
		@(negedge clk);
		if (prev && !rx) begin
			repeat (4) @(negedge clk);
			for (int i = 0; i < (nine ? 10 : 9); i++) begin
				repeat (8) @(negedge clk);
				got[i] = rx;
			end
			frames++;
		end
		prev = rx;
	end
endmodule

/* File: testbench/async_serial_port_8_9_bit_test.sv */
// Self-checking bench: register accesses over AHB-Lite and frames to a peer.
// Assumes one 250 MHz clock, one slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module async_serial_port_8_9_bit_test
	import asp_pkg::*;
;
	logic clk, resetn, hwrite, hreadyout, hresp, tx_pin, rx_pin, irq;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0] cv;
	int n_fail, num_checks;
	// Receive cases: control written (FF keeps it), framing, data, ninth, stop
	logic [7:0] rcv [6] = '{8'h10, 8'hFF, 8'h30, 8'hB0, 8'hFF, 8'h90};
	logic rnine [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	logic [7:0] rdat [6] = '{8'h3C, 8'h55, 8'h66, 8'h77, 8'h81, 8'h92};
	logic rb9 [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	logic rstop [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [7:0] ectl [6] = '{8'h55, 8'h55, 8'h70, 8'hF0, 8'hF5, 8'hD1};
	logic [7:0] edat [6] = '{8'h3C, 8'h3C, 8'h3C, 8'h3C, 8'h81, 8'h92};

	asp_uart DUT (.clk(clk), .resetn(resetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.serial_transmit_pin(tx_pin), .serial_receive_pin(rx_pin), .irq(irq));
	asp_peer peer (.clk(clk), .rx(tx_pin), .tx(rx_pin));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic hang();
		n_fail++;
		conclude();
	endtask
	// Wait for hready high at a rising edge; data read is taken at the falling edge before it
	task automatic rdy();
		int n;
		n = 0;
		@(negedge clk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 40) hang();
			@(negedge clk);
		end
		rd = hrdata;
		@(posedge clk);
	endtask
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		haddr <= a;
		hwrite <= w;
		htrans <= ASP_HTRANS_NONSEQ;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		check("hresp", hresp, 32'h0);
	endtask
	task automatic wait_frame(input int f);
		int n;
		n = 0;
		while (peer.frames != f) begin
			n++;
			if (n > 400) hang();
			@(posedge clk);
		end
	endtask

	initial begin
		resetn = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		n_fail = 0;
		num_checks = 0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		bus(ASP_CTRL_ADDR, 1'b0, 32'h0);
		check("ctrl reset", rd, 32'h40);
		bus(ASP_DATA_ADDR, 1'b0, 32'h0);
		check("data reset", rd, 32'h0);
		bus(ASP_CTRL_ADDR, 1'b1, 32'h0);
		bus(ASP_CTRL_ADDR, 1'b0, 32'h0);
		check("ctrl unused bit", rd, 32'h40);
		bus(32'h200, 1'b1, 32'hFF);
		bus(32'h200, 1'b0, 32'h0);
		check("unmapped", rd, 32'h0);
		bus(ASP_TIMER_ADDR, 1'b1, 32'h3FC);
		bus(ASP_TIMER_ADDR, 1'b0, 32'h0);
		check("timer", rd, 32'h3FC);
		// Transmit in 8-bit framing, then 9-bit with ninth bit 1 and 0
		for (int i = 0; i < 3; i++) begin
			cv = (i == 0) ? 8'h08 : ((i == 1) ? 8'h88 : 8'h80);
			peer.nine = (i > 0);
			bus(ASP_CTRL_ADDR, 1'b1, cv);
			bus(ASP_DATA_ADDR, 1'b1, 8'hA5 ^ i);
			bus(ASP_CTRL_ADDR, 1'b0, 32'h0);
			check("ti early", rd[1], 32'h0);
			wait_frame(i + 1);
			check("tx data", peer.got[7:0], 8'hA5 ^ i);
			check("tx ninth", peer.got[8], i != 2);
			check("tx stop", peer.got[8 + (i > 0)], 32'h1);
			repeat (40) @(posedge clk);
			bus(ASP_CTRL_ADDR, 1'b0, 32'h0);
			check("ti set", rd, cv | 8'h42);
			check("irq tx", irq, 32'h1);
		end
		bus(ASP_TIMER_ADDR, 1'b1, 32'h1FC);
		repeat (2) @(posedge clk);
		check("irq masked", irq, 32'h0);
		bus(ASP_TIMER_ADDR, 1'b1, 32'h3FC);
		// Receiver disabled: frame is ignored
		peer.nine = 1'b0;
		bus(ASP_CTRL_ADDR, 1'b1, 32'h0);
		peer.send(8'h3C, 1'b0, 1'b1);
		repeat (4) @(posedge clk);
		bus(ASP_CTRL_ADDR, 1'b0, 32'h0);
		check("rx disabled", rd, 32'h40);
		// Accept, overrun, filter rejects in both framings, filter accepts in 9-bit framing
		for (int i = 0; i < 6; i++) begin
			peer.nine = rnine[i];
			if (rcv[i] != 8'hFF) bus(ASP_CTRL_ADDR, 1'b1, rcv[i]);
			peer.send(rdat[i], rb9[i], rstop[i]);
			repeat (4) @(posedge clk);
			bus(ASP_CTRL_ADDR, 1'b0, 32'h0);
			check("rx ctrl", rd, ectl[i]);
			bus(ASP_DATA_ADDR, 1'b0, 32'h0);
			check("rx data", rd, edat[i]);
			check("irq rx", irq, ectl[i][0]);
		end
		conclude();
	end
endmodule
